//--- rtl/peipm_pkg.sv
package peipm_pkg;

  // pin counts of the three ports
  localparam int n_ad = 8;
  localparam int n_r  = 4;
  localparam int n_u  = 8;

  // register indices; byte address is four times the index
  localparam logic [9:0] idx_ad_ie  = 10'h28c;
  localparam logic [9:0] idx_ad_if  = 10'h28d;
  localparam logic [9:0] idx_r_ie   = 10'h28e;
  localparam logic [9:0] idx_r_if   = 10'h28f;
  localparam logic [9:0] idx_u_dat  = 10'h290;
  localparam logic [9:0] idx_r_pol  = 10'h291;
  localparam logic [9:0] idx_u_dir  = 10'h292;
  localparam logic [9:0] idx_istat  = 10'h293;
  localparam logic [9:0] idx_imask  = 10'h294;

  // event status layout: analog pins low, poly pins above
  localparam int evt_ad_lsb = 0;
  localparam int evt_r_lsb  = 8;
  localparam int n_evt      = 12;

  // reset values
  localparam logic [7:0]  rst_byte = 8'h00;
  localparam logic [3:0]  rst_nib  = 4'h0;
  localparam logic [11:0] rst_evt  = 12'h000;

  // alternate functions that may own motor port pins
  typedef struct packed {
    logic [7:0] pwm_en;
    logic [7:0] pwm_val;
    logic [3:0] tim_en;
    logic [3:0] tim_val;
  } peipm_alt_t;

  // motor port pad drive, oe_b low while the pad is driven
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe_b;
  } peipm_drv_t;

endpackage

//--- rtl/peipm_top.sv
`timescale 1ns/1ps

module peipm_top #(
  parameter int n_ad = peipm_pkg::n_ad,
  parameter int n_r  = peipm_pkg::n_r,
  parameter int n_u  = peipm_pkg::n_u
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire logic [11:0]          avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic [n_ad-1:0]      analog_pin_in,
  input  wire logic [n_r-1:0]       poly_pin_in,
  input  wire logic [n_u-1:0]       motor_pin_in,
  input  wire peipm_pkg::peipm_alt_t alt_func,
  output peipm_pkg::peipm_drv_t     motor_pin_drv,
  output logic                      analog_port_irq,
  output logic                      poly_port_irq,
  output logic                      irq
);

  // pin synchronisers and previous-sample stages
  logic [n_ad-1:0] ad_s1, ad_s2, ad_prev, next_ad_s1, next_ad_s2, next_ad_prev;
  logic [n_r-1:0]  r_s1, r_s2, r_prev, next_r_s1, next_r_s2, next_r_prev;
  logic [n_u-1:0]  u_s1, u_s2, next_u_s1, next_u_s2;

  // registers
  logic [n_ad-1:0]  analog_port_irq_enables, next_ad_ie;
  logic [n_ad-1:0]  analog_port_edge_flags, next_ad_if;
  logic [n_r-1:0]   poly_port_irq_enables, next_r_ie;
  logic [n_r-1:0]   poly_port_edge_flags, next_r_if;
  logic [n_r-1:0]   poly_port_edge_polarity, next_r_pol;
  logic [n_u-1:0]   motor_port_data, next_u_dat;
  logic [n_u-1:0]   motor_port_direction, next_u_dir;
  logic [11:0]      irq_status, next_stat;
  logic [11:0]      irq_mask, next_mask;

  // bus state and outputs
  logic             next_wait;
  logic [31:0]      next_rdata;
  peipm_pkg::peipm_drv_t next_drv;
  logic             next_ad_irq, next_r_irq, next_irq;

  // decoded events
  logic [n_ad-1:0] ad_fall;
  logic [n_r-1:0]  r_edge;
  logic            req, acc;
  logic [11:0]     stat_clr;

  // true when the current request addresses the given register index
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[11:2] == idx);
  endfunction

  // synchroniser next values; first stage read only by the second
  always_comb begin
    next_ad_s1   = analog_pin_in;
    next_ad_s2   = ad_s1;
    next_ad_prev = ad_s2;
    next_r_s1    = poly_pin_in;
    next_r_s2    = r_s1;
    next_r_prev  = r_s2;
    next_u_s1    = motor_pin_in;
    next_u_s2    = u_s1;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ad_s1   <= '0;
      ad_s2   <= '0;
      ad_prev <= '0;
      r_s1    <= '0;
      r_s2    <= '0;
      r_prev  <= '0;
      u_s1    <= '0;
      u_s2    <= '0;
    end else begin
      ad_s1   <= next_ad_s1;
      ad_s2   <= next_ad_s2;
      ad_prev <= next_ad_prev;
      r_s1    <= next_r_s1;
      r_s2    <= next_r_s2;
      r_prev  <= next_r_prev;
      u_s1    <= next_u_s1;
      u_s2    <= next_u_s2;
    end
  end

  // edge detection on synchronised levels only
  assign ad_fall = ad_prev & ~ad_s2;
  // per-pin polarity picks rising or falling
  assign r_edge  = (poly_port_edge_polarity & ~r_prev & r_s2)
                 | (~poly_port_edge_polarity & r_prev & ~r_s2);

  // one wait cycle: waitrequest drops for exactly one edge per request
  assign req = avs_read | avs_write;
  assign acc = req & ~avs_waitrequest;

  // read-clear drops only bits actually returned, so late events survive
  assign stat_clr = (acc && avs_read && hit(avs_address, peipm_pkg::idx_istat))
                  ? avs_readdata[11:0] : 12'h000;

  // register file next values; writes land on the accepting edge
  always_comb begin
    next_ad_ie = analog_port_irq_enables;
    next_r_ie  = poly_port_irq_enables;
    next_r_pol = poly_port_edge_polarity;
    next_u_dat = motor_port_data;
    next_u_dir = motor_port_direction;
    next_mask  = irq_mask;
    next_ad_if = analog_port_edge_flags;
    next_r_if  = poly_port_edge_flags;
    if (acc && avs_write && avs_byteenable[0]) begin
      if (hit(avs_address, peipm_pkg::idx_ad_ie)) begin
        next_ad_ie = avs_writedata[n_ad-1:0];
      end else if (hit(avs_address, peipm_pkg::idx_r_ie)) begin
        next_r_ie = avs_writedata[n_r-1:0];
      end else if (hit(avs_address, peipm_pkg::idx_r_pol)) begin
        next_r_pol = avs_writedata[n_r-1:0];
      end else if (hit(avs_address, peipm_pkg::idx_u_dat)) begin
        next_u_dat = avs_writedata[n_u-1:0];
      end else if (hit(avs_address, peipm_pkg::idx_u_dir)) begin
        next_u_dir = avs_writedata[n_u-1:0];
      end else if (hit(avs_address, peipm_pkg::idx_imask)) begin
        next_mask = avs_writedata[11:0];
      end else if (hit(avs_address, peipm_pkg::idx_ad_if)) begin
        next_ad_if = analog_port_edge_flags & ~avs_writedata[n_ad-1:0];
      end else if (hit(avs_address, peipm_pkg::idx_r_if)) begin
        next_r_if = poly_port_edge_flags & ~avs_writedata[n_r-1:0];
      end
    end
    // set applied last so a same-cycle edge beats the clear
    next_ad_if = next_ad_if | ad_fall;
    next_r_if  = next_r_if | r_edge;
    next_stat  = (irq_status & ~stat_clr) | {r_edge, ad_fall};
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_port_irq_enables <= peipm_pkg::rst_byte;
      analog_port_edge_flags  <= peipm_pkg::rst_byte;
      poly_port_irq_enables   <= peipm_pkg::rst_nib;
      poly_port_edge_flags    <= peipm_pkg::rst_nib;
      poly_port_edge_polarity <= peipm_pkg::rst_nib;
      motor_port_data         <= peipm_pkg::rst_byte;
      motor_port_direction    <= peipm_pkg::rst_byte;
      irq_status              <= peipm_pkg::rst_evt;
      irq_mask                <= peipm_pkg::rst_evt;
    end else begin
      analog_port_irq_enables <= next_ad_ie;
      analog_port_edge_flags  <= next_ad_if;
      poly_port_irq_enables   <= next_r_ie;
      poly_port_edge_flags    <= next_r_if;
      poly_port_edge_polarity <= next_r_pol;
      motor_port_data         <= next_u_dat;
      motor_port_direction    <= next_u_dir;
      irq_status              <= next_stat;
      irq_mask                <= next_mask;
    end
  end

  // bus answer: read data is captured while waitrequest is still high
  always_comb begin
    next_wait  = ~(req & avs_waitrequest);
    next_rdata = avs_readdata;
    if (req && avs_waitrequest) begin
      next_rdata = 32'h0000_0000;                                       // unmapped reads zero
      if (hit(avs_address, peipm_pkg::idx_ad_ie)) begin
        next_rdata[n_ad-1:0] = analog_port_irq_enables;
      end else if (hit(avs_address, peipm_pkg::idx_ad_if)) begin
        next_rdata[n_ad-1:0] = analog_port_edge_flags;
      end else if (hit(avs_address, peipm_pkg::idx_r_ie)) begin
        next_rdata[n_r-1:0] = poly_port_irq_enables;
      end else if (hit(avs_address, peipm_pkg::idx_r_if)) begin
        next_rdata[n_r-1:0] = poly_port_edge_flags;
      end else if (hit(avs_address, peipm_pkg::idx_r_pol)) begin
        next_rdata[n_r-1:0] = poly_port_edge_polarity;
      end else if (hit(avs_address, peipm_pkg::idx_u_dat)) begin
        next_rdata[n_u-1:0] = (motor_port_direction & motor_port_data)
                            | (~motor_port_direction & u_s2);
      end else if (hit(avs_address, peipm_pkg::idx_u_dir)) begin
        next_rdata[n_u-1:0] = motor_port_direction;
      end else if (hit(avs_address, peipm_pkg::idx_istat)) begin
        next_rdata[11:0] = irq_status;
      end else if (hit(avs_address, peipm_pkg::idx_imask)) begin
        next_rdata[11:0] = irq_mask;
      end
    end
  end

  // pad mux: pwm first, then timer on even pins, then gpio
  always_comb begin
    next_drv = motor_pin_drv;
    for (int i = 0; i < n_u; i++) begin
      if (alt_func.pwm_en[i]) begin
        next_drv.level[i] = alt_func.pwm_val[i];
        next_drv.oe_b[i]  = 1'b0;
      end else if ((i % 2 == 0) && alt_func.tim_en[i/2]) begin
        next_drv.level[i] = alt_func.tim_val[i/2];
        next_drv.oe_b[i]  = 1'b0;
      end else begin
        next_drv.level[i] = motor_port_data[i];
        next_drv.oe_b[i]  = ~motor_port_direction[i];
      end
    end
    next_ad_irq = |(analog_port_edge_flags & analog_port_irq_enables);
    next_r_irq  = |(poly_port_edge_flags & poly_port_irq_enables);
    next_irq    = |(irq_status & irq_mask);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      motor_pin_drv   <= '{level: 8'h00, oe_b: 8'hff};
      analog_port_irq <= 1'b0;
      poly_port_irq   <= 1'b0;
      irq             <= 1'b0;
    end else begin
      avs_waitrequest <= next_wait;
      avs_readdata    <= next_rdata;
      motor_pin_drv   <= next_drv;
      analog_port_irq <= next_ad_irq;
      poly_port_irq   <= next_r_irq;
      irq             <= next_irq;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  ad_flag_set_a: assert property (ad_fall != 0 |=>
    (analog_port_edge_flags & $past(ad_fall)) == $past(ad_fall))
    else $error("analog flag missed a falling edge");
  ad_clear_a: assert property (
    acc && avs_write && avs_byteenable[0] && hit(avs_address, peipm_pkg::idx_ad_if) && ad_fall == 0
    |=> (analog_port_edge_flags & $past(avs_writedata[7:0])) == 8'h00)
    else $error("analog flag not cleared by write one");
  ad_hold_a: assert property (
    !(acc && avs_write && hit(avs_address, peipm_pkg::idx_ad_if))
    |=> (analog_port_edge_flags & $past(analog_port_edge_flags)) == $past(analog_port_edge_flags))
    else $error("analog flag dropped without clear");
  r_edge_a: assert property ($rose(r_s2[0]) && poly_port_edge_polarity[0]
    ##1 1'b1 |-> poly_port_edge_flags[0])
    else $error("poly flag missed selected edge");
  r_clear_a: assert property (
    acc && avs_write && avs_byteenable[0] && hit(avs_address, peipm_pkg::idx_r_if) && r_edge == 0
    |=> (poly_port_edge_flags & $past(avs_writedata[3:0])) == 4'h0)
    else $error("poly flag not cleared by write one");
  set_wins_a: assert property (ad_fall[0] |=> analog_port_edge_flags[0])
    else $error("edge lost against clear");
  ad_irq_a: assert property (
    |(analog_port_edge_flags & analog_port_irq_enables) |=> analog_port_irq)
    else $error("analog request missing");
  r_mask_a: assert property (
    (poly_port_irq_enables == 4'h0) [*2] |-> !poly_port_irq)
    else $error("masked poly flag raised request");
  pwm_first_a: assert property (alt_func.pwm_en[6] |=>
    motor_pin_drv.level[6] == $past(alt_func.pwm_val[6]) && !motor_pin_drv.oe_b[6])
    else $error("pwm lost precedence on even pin");
  tim_pin_a: assert property (!alt_func.pwm_en[6] && alt_func.tim_en[3] |=>
    motor_pin_drv.level[6] == $past(alt_func.tim_val[3]))
    else $error("timer channel not on its pin");
  rd_back_a: assert property (
    req && avs_waitrequest && hit(avs_address, peipm_pkg::idx_u_dat) |=>
    avs_readdata[7:0] == (($past(motor_port_direction) & $past(motor_port_data))
                        | (~$past(motor_port_direction) & $past(u_s2))))
    else $error("data read-back source wrong");
  rd_zero_a: assert property (avs_readdata[31:12] == 20'h00000)
    else $error("unused read bits not zero");
  bus_ack_a: assert property (req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not one cycle low");

  // enable writes land as written; narrow poly register drops the upper bits
  ad_ie_wr_a: assert property (
    acc && avs_write && avs_byteenable[0] && hit(avs_address, peipm_pkg::idx_ad_ie)
    |=> analog_port_irq_enables == $past(avs_writedata[7:0]))
    else $error("analog enable write lost");
  r_ie_wr_a: assert property (
    acc && avs_write && avs_byteenable[0] && hit(avs_address, peipm_pkg::idx_r_ie)
    |=> poly_port_irq_enables == $past(avs_writedata[3:0]))
    else $error("poly enable write lost");
  r_fall_a: assert property ($fell(r_s2[1]) && !poly_port_edge_polarity[1]
    |=> poly_port_edge_flags[1])
    else $error("poly flag missed falling edge");
  r_hold_a: assert property (
    !(acc && avs_write && hit(avs_address, peipm_pkg::idx_r_if))
    |=> (poly_port_edge_flags & $past(poly_port_edge_flags)) == $past(poly_port_edge_flags))
    else $error("poly flag dropped without clear");
  r_irq_a: assert property (
    |(poly_port_edge_flags & poly_port_irq_enables) |=> poly_port_irq)
    else $error("poly request missing");
  ad_mask_a: assert property (
    (analog_port_irq_enables == 8'h00) [*2] |-> !analog_port_irq)
    else $error("masked analog flag raised request");

  // pad precedence, read padding and the summary request
  pwm_odd_a: assert property (alt_func.pwm_en[1] |=>
    motor_pin_drv.level[1] == $past(alt_func.pwm_val[1]) && !motor_pin_drv.oe_b[1])
    else $error("pwm not on odd pin");
  gpio_pin_a: assert property (!alt_func.pwm_en[3] |=>
    motor_pin_drv.level[3] == $past(motor_port_data[3])
    && motor_pin_drv.oe_b[3] == !$past(motor_port_direction[3]))
    else $error("gpio pad drive wrong");
  flag_pad_a: assert property (
    req && avs_waitrequest && hit(avs_address, peipm_pkg::idx_r_if) |=> avs_readdata[7:4] == 4'h0)
    else $error("unused flag bits not zero");
  sum_irq_a: assert property (|(irq_status & irq_mask) |=> irq)
    else $error("summary request missing");
  stat_keep_a: assert property (ad_fall[0] |=> irq_status[0])
    else $error("event lost against status read");

  ad_event_c: cover property (ad_fall != 0 ##1 analog_port_irq_enables != 0 ##1 analog_port_irq);
  clear_race_c: cover property (acc && avs_write && hit(avs_address, peipm_pkg::idx_ad_if) && ad_fall != 0);
  rise_c: cover property (r_edge != 0 && poly_port_edge_polarity != 0);
  pwm_c: cover property (alt_func.pwm_en[0] && alt_func.tim_en[0]);
  pwm_pin6_c: cover property (alt_func.pwm_en[6] && alt_func.tim_en[3]);

endmodule

//--- bench/test_port_edge_irq_and_pin_mux.sv
`timescale 1ns/1ps

module test_port_edge_irq_and_pin_mux;
  logic                  ref_clk;
  logic                  rst_b;
  logic [11:0]           avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic [31:0]           avs_writedata;
  logic [3:0]            avs_byteenable;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [7:0]            analog_pin_in;
  logic [3:0]            poly_pin_in;
  logic [7:0]            motor_pin_in;
  peipm_pkg::peipm_alt_t alt_func;
  peipm_pkg::peipm_drv_t motor_pin_drv;
  logic                  analog_port_irq;
  logic                  poly_port_irq;
  logic                  irq;
  int                    err_total;
  int                    cmp_count;
  logic [31:0]           rd;

  peipm_top u_dut (
    .ref_clk         (ref_clk),
    .rst_b           (rst_b),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .analog_pin_in   (analog_pin_in),
    .poly_pin_in     (poly_pin_in),
    .motor_pin_in    (motor_pin_in),
    .alt_func        (alt_func),
    .motor_pin_drv   (motor_pin_drv),
    .analog_port_irq (analog_port_irq),
    .poly_port_irq   (poly_port_irq),
    .irq             (irq)
  );

  // 10 mhz clock
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  // single place where the run ends
  task end_of_test;
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // register value compare
  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // pin and interrupt output compare
  task chk_pin(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task bus(input logic wr, input logic [9:0] idx, input logic [11:0] d, input logic [3:0] be);
    int n;
    avs_address    <= {idx, 2'b00};
    avs_writedata  <= {20'h0, d};
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) begin
        err_total++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
        end_of_test();
      end
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    // idle edge so the next request never lands in the same time step
    @(posedge ref_clk);
  endtask

  task wr(input logic [9:0] idx, input logic [11:0] d);
    bus(1'b1, idx, d, 4'hf);
  endtask

  task rdchk(input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 12'h000, 4'hf);
    chk_val(rd, exp);
  endtask

  initial begin
    err_total      = 0;
    cmp_count      = 0;
    rst_b          = 1'b0;
    avs_address    = 12'h000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'h0;
    analog_pin_in  = 8'hff;
    poly_pin_in    = 4'h0;
    motor_pin_in   = 8'h00;
    alt_func       = '0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);

    // every register zero after reset, unmapped word reads zero
    for (int i = 0; i < 9; i++) rdchk(peipm_pkg::idx_ad_ie + 10'(i), 32'h0);
    rdchk(10'h295, 32'h0);
    chk_pin({13'h0, analog_port_irq, poly_port_irq, irq}, 16'h0);
    $display("test reset_values done");

    // analog port: falling edges, write-one clear, masking
    wr(peipm_pkg::idx_ad_ie, 12'h0ff);
    rdchk(peipm_pkg::idx_ad_ie, 32'hff);
    wr(peipm_pkg::idx_ad_ie, 12'h005);
    bus(1'b1, peipm_pkg::idx_ad_ie, 12'h0ff, 4'h0);
    rdchk(peipm_pkg::idx_ad_ie, 32'h05);
    analog_pin_in <= 8'hfc; // digital input taken as enabled
    tick(6);
    rdchk(peipm_pkg::idx_ad_if, 32'h03);
    chk_pin({15'h0, analog_port_irq}, 16'h1);
    wr(peipm_pkg::idx_ad_if, 12'h001);
    rdchk(peipm_pkg::idx_ad_if, 32'h02);
    tick(2);
    chk_pin({15'h0, analog_port_irq}, 16'h0);
    analog_pin_in <= 8'hff;
    tick(6);
    rdchk(peipm_pkg::idx_ad_if, 32'h02);
    // summary status and mask; the read clears status
    wr(peipm_pkg::idx_imask, 12'h002);
    tick(2);
    chk_pin({15'h0, irq}, 16'h1);
    rdchk(peipm_pkg::idx_istat, 32'h003);
    tick(2);
    chk_pin({15'h0, irq}, 16'h0);
    rdchk(peipm_pkg::idx_istat, 32'h0);
    $display("test analog_port done");

    // poly port: per-pin polarity, write-one clear
    wr(peipm_pkg::idx_r_ie, 12'h0ff);
    rdchk(peipm_pkg::idx_r_ie, 32'h0f);
    wr(peipm_pkg::idx_r_pol, 12'h005);
    rdchk(peipm_pkg::idx_r_pol, 32'h05);
    wr(peipm_pkg::idx_r_ie, 12'h008);
    poly_pin_in <= 4'hf;
    tick(6);
    rdchk(peipm_pkg::idx_r_if, 32'h05);
    chk_pin({15'h0, poly_port_irq}, 16'h0);
    poly_pin_in <= 4'h0;
    tick(6);
    rdchk(peipm_pkg::idx_r_if, 32'h0f);
    chk_pin({15'h0, poly_port_irq}, 16'h1);
    wr(peipm_pkg::idx_r_if, 12'h0f0);
    rdchk(peipm_pkg::idx_r_if, 32'h0f);
    wr(peipm_pkg::idx_r_if, 12'h00f);
    rdchk(peipm_pkg::idx_r_if, 32'h00);
    tick(2);
    chk_pin({15'h0, poly_port_irq}, 16'h0);
    rdchk(peipm_pkg::idx_istat, 32'hf00);
    $display("test poly_port done");

    // motor port: read-back select and pad precedence
    wr(peipm_pkg::idx_u_dir, 12'h0f0);
    wr(peipm_pkg::idx_u_dat, 12'h0a5);
    motor_pin_in <= 8'h3c;
    tick(4);
    rdchk(peipm_pkg::idx_u_dat, 32'hac);
    chk_pin(motor_pin_drv, 16'ha50f);
    alt_func <= '{pwm_en: 8'h07, pwm_val: 8'h02, tim_en: 4'hb, tim_val: 4'hb};
    tick(3);
    chk_pin(motor_pin_drv, 16'he208);
    alt_func <= '{pwm_en: 8'h00, pwm_val: 8'hff, tim_en: 4'h4, tim_val: 4'h4};
    tick(3);
    chk_pin(motor_pin_drv, 16'hb50f);
    alt_func <= '{pwm_en: 8'h40, pwm_val: 8'h40, tim_en: 4'h8, tim_val: 4'h0};
    tick(3);
    chk_pin(motor_pin_drv, 16'he50f);
    // capture use: every output function released first
    alt_func <= '0;
    motor_pin_in <= 8'hc3;
    tick(4);
    rdchk(peipm_pkg::idx_u_dat, 32'ha3);
    $display("test motor_port done");
    end_of_test();
  end
endmodule
